/* File: pgpio_top.sv */
// Paged GPIO ports 4..7: register file, page decode and pin instances
`timescale 1ns/100ps
`include "pgpio_defs.svh"

// What this block does
// - Normal port reads return the sampled pin level.
// - Read-modify-write reads return the stored data register instead.
// - Port four has pins only at bits five to seven.
// - Port registers respond only while register page select is 0x0F.
// - Push-pull: data 0 drives low, data 1 drives high.
// - Open-drain: data 0 drives low, data 1 releases the pin.
// - Mode bit 1 selects push-pull, 0 open-drain, per pin.
// - Every pin comes out of reset in open-drain drive.
// - Weak pull-ups on unless the global disable bit is set.
// - Data and mode registers exist even without bonded pins; absent bits read as zero.
module pgpio_top (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Special-function register access
  input  wire logic [7:0]  SFR_PAGE,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic        SFR_WR,
  input  wire logic [7:0]  SFR_WDATA,
  input  wire logic        SFR_RD,
  input  wire logic        SFR_RMW,
  output logic [7:0]       SFR_RDATA,
  output logic             SFR_RVALID,
  output logic             SFR_HIT,
  // Crossbar configuration
  input  wire logic        WEAK_PULLUP_DIS,
  // Port pins, bits 7:0 port 4 up to bits 31:24 port 7
  input  wire logic [31:0] PIN_IN,
  output logic [31:0]      PIN_OUT,
  output logic [31:0]      PIN_OE,
  output logic [31:0]      PULLUP_EN
);

  localparam int NP = `PGPIO_NUM_PORTS;
  localparam int PW = `PGPIO_PORT_W;

  // Address decode; outside the port page nothing here answers
  function automatic pgpio_pkg::pgpio_sel_e decode_sel(
    input logic [7:0] page,
    input logic [7:0] addr
  );
    pgpio_pkg::pgpio_sel_e sel;
    sel = pgpio_pkg::SEL_NONE;
    if (page == `PGPIO_PAGE_PORTS) begin
      case (addr)
        `PGPIO_ADDR_DATA4: sel = pgpio_pkg::SEL_DATA4;
        `PGPIO_ADDR_DATA5: sel = pgpio_pkg::SEL_DATA5;
        `PGPIO_ADDR_DATA6: sel = pgpio_pkg::SEL_DATA6;
        `PGPIO_ADDR_DATA7: sel = pgpio_pkg::SEL_DATA7;
        `PGPIO_ADDR_MODE4: sel = pgpio_pkg::SEL_MODE4;
        `PGPIO_ADDR_MODE5: sel = pgpio_pkg::SEL_MODE5;
        `PGPIO_ADDR_MODE6: sel = pgpio_pkg::SEL_MODE6;
        `PGPIO_ADDR_MODE7: sel = pgpio_pkg::SEL_MODE7;
        default:           sel = pgpio_pkg::SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Mask of pins that physically exist on a port
  function automatic logic [7:0] present_mask(input int p);
    return (p == 0) ? `PGPIO_PRESENT_P4 : `PGPIO_PRESENT_FULL;
  endfunction

  pgpio_pkg::pgpio_sel_e sel;
  logic [8:0]            sel_bits;
  logic                  wr_any;
  logic                  rd_any;

  pgpio_pkg::pgpio_byte_t data_r   [NP];
  pgpio_pkg::pgpio_byte_t mode_r   [NP];
  pgpio_pkg::pgpio_byte_t data_rd  [NP];
  pgpio_pkg::pgpio_byte_t mode_rd  [NP];
  pgpio_pkg::pgpio_byte_t level_rd [NP];

  logic [NP-1:0] wr_data;
  logic [NP-1:0] wr_mode;
  logic [NP-1:0] hit_data;
  logic [NP-1:0] hit_mode;

  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       rvalid_r;
  logic       hit_r;
  logic       hit_nxt;

  // Access qualifiers
  assign sel      = decode_sel(SFR_PAGE, SFR_ADDR);
  assign sel_bits = sel;
  assign wr_any   = SFR_WR;
  assign rd_any   = SFR_RD & ~SFR_WR;

  pgpio_port_if port_if [NP] ();

  genvar p;
  generate
    for (p = 0; p < NP; p = p + 1) begin : g_port
      // Per-port write strobes from the one-hot select
      assign hit_data[p] = sel_bits[`PGPIO_SEL_DATA_LSB + p];
      assign hit_mode[p] = sel_bits[`PGPIO_SEL_MODE_LSB + p];
      assign wr_data[p]  = wr_any & hit_data[p];
      assign wr_mode[p]  = wr_any & hit_mode[p];

      // Data and mode storage; exists whether or not pins are bonded
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          data_r[p] <= `PGPIO_DATA_RST;
          mode_r[p] <= `PGPIO_MODE_RST; // Open-drain everywhere
        end else begin
          if (wr_data[p]) begin
            data_r[p] <= SFR_WDATA;
          end
          if (wr_mode[p]) begin
            mode_r[p] <= SFR_WDATA; // Bit per pin, 1 push-pull
          end
        end
      end

      // Read views, masked to existing pins
      assign data_rd[p] = data_r[p] & present_mask(p);
      assign mode_rd[p] = mode_r[p] & present_mask(p);
      assign level_rd[p] = port_if[p].level;

      // Connect register side of the carrier
      assign port_if[p].data   = data_r[p];
      assign port_if[p].mode   = mode_r[p];
      assign port_if[p].pu_dis = WEAK_PULLUP_DIS;

      // Pin logic for this port
      pgpio_port_pins #(
        .PRESENT (present_mask(p))
      ) u_pins (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .port      (port_if[p]),
        .pin_in    (PIN_IN[p*PW +: PW]),
        .pin_out   (PIN_OUT[p*PW +: PW]),
        .pin_oe    (PIN_OE[p*PW +: PW]),
        .pullup_en (PULLUP_EN[p*PW +: PW])
      );
    end
  endgenerate

  // Read data select; only the read phase of read-modify-write sees the latch
  always_comb begin
    rdata_nxt = `PGPIO_UNMAPPED_READ;
    case (sel)
      pgpio_pkg::SEL_DATA4: rdata_nxt = SFR_RMW ? data_rd[0] : level_rd[0];
      pgpio_pkg::SEL_DATA5: rdata_nxt = SFR_RMW ? data_rd[1] : level_rd[1];
      pgpio_pkg::SEL_DATA6: rdata_nxt = SFR_RMW ? data_rd[2] : level_rd[2];
      pgpio_pkg::SEL_DATA7: rdata_nxt = SFR_RMW ? data_rd[3] : level_rd[3];
      pgpio_pkg::SEL_MODE4: rdata_nxt = mode_rd[0];
      pgpio_pkg::SEL_MODE5: rdata_nxt = mode_rd[1];
      pgpio_pkg::SEL_MODE6: rdata_nxt = mode_rd[2];
      pgpio_pkg::SEL_MODE7: rdata_nxt = mode_rd[3];
      default:              rdata_nxt = `PGPIO_UNMAPPED_READ;
    endcase
  end

  // Page and address hit, reported one cycle after any access
  assign hit_nxt = (SFR_RD | SFR_WR) & (sel != pgpio_pkg::SEL_NONE);

  // Registered read answer; data holds until the next read
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r  <= `PGPIO_RDATA_RST;
      rvalid_r <= 1'b0;
      hit_r    <= 1'b0;
    end else begin
      rvalid_r <= rd_any;
      hit_r    <= hit_nxt;
      if (rd_any) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign SFR_RDATA  = rdata_r;
  assign SFR_RVALID = rvalid_r;
  assign SFR_HIT    = hit_r;

endmodule

/* File: pgpio_defs.svh */
// Constants for the paged port 4..7 GPIO block
`ifndef PGPIO_DEFS_SVH
`define PGPIO_DEFS_SVH

// Register page that holds the port registers
`define PGPIO_PAGE_PORTS     8'h0F

// Port data register addresses
`define PGPIO_ADDR_DATA4     8'hC8
`define PGPIO_ADDR_DATA5     8'hD8
`define PGPIO_ADDR_DATA6     8'hE8
`define PGPIO_ADDR_DATA7     8'hF8

// Port output mode register addresses
`define PGPIO_ADDR_MODE4     8'h9C
`define PGPIO_ADDR_MODE5     8'h9D
`define PGPIO_ADDR_MODE6     8'h9E
`define PGPIO_ADDR_MODE7     8'h9F

// Reset values
`define PGPIO_DATA_RST       8'hFF
`define PGPIO_MODE_RST       8'h00
`define PGPIO_LEVEL_RST      8'hFF
`define PGPIO_RDATA_RST      8'h00
`define PGPIO_UNMAPPED_READ  8'h00

// Pins present behind each port, bit per pin
`define PGPIO_PRESENT_P4     8'hE0
`define PGPIO_PRESENT_FULL   8'hFF

// Geometry
`define PGPIO_NUM_PORTS      4
`define PGPIO_PORT_W         8
`define PGPIO_SEL_DATA_LSB   1
`define PGPIO_SEL_MODE_LSB   5

`endif

/* File: pgpio_pkg.sv */
// Types shared by the paged port 4..7 GPIO block
package pgpio_pkg;

  typedef logic [7:0] pgpio_byte_t;

  // One-hot register select
  typedef enum logic [8:0] {
    SEL_NONE  = 9'h001,
    SEL_DATA4 = 9'h002,
    SEL_DATA5 = 9'h004,
    SEL_DATA6 = 9'h008,
    SEL_DATA7 = 9'h010,
    SEL_MODE4 = 9'h020,
    SEL_MODE5 = 9'h040,
    SEL_MODE6 = 9'h080,
    SEL_MODE7 = 9'h100
  } pgpio_sel_e;

endpackage

/* File: pgpio_port_if.sv */
// Carrier between the register file and one port's pin logic
`timescale 1ns/100ps
interface pgpio_port_if;
  logic [7:0] data;
  logic [7:0] mode;
  logic       pu_dis;
  logic [7:0] level;

  modport regs (
    output data,
    output mode,
    output pu_dis,
    input  level
  );

  modport pins (
    input  data,
    input  mode,
    input  pu_dis,
    output level
  );
endinterface

/* File: pgpio_port_pins.sv */
// Pin side of one byte-wide port: input sampling, drive and pull-up
`timescale 1ns/100ps
`include "pgpio_defs.svh"
module pgpio_port_pins #(
  parameter logic [7:0] PRESENT = `PGPIO_PRESENT_FULL
) (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // Register side
  pgpio_port_if.pins    port,
  // Pin side
  input  wire logic [7:0] pin_in,
  output logic [7:0]      pin_out,
  output logic [7:0]      pin_oe,
  output logic [7:0]      pullup_en
);

  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] sync3_r;
  logic [7:0] level_r;
  logic [7:0] level_nxt;
  logic [7:0] out_nxt;
  logic [7:0] oe_nxt;
  logic [7:0] pu_nxt;

  // Three-stage sampler; sync1 feeds only sync2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= `PGPIO_LEVEL_RST;
      sync2_r <= `PGPIO_LEVEL_RST;
      sync3_r <= `PGPIO_LEVEL_RST;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Level moves only when stages two and three agree; input path never gated
  genvar i;
  generate
    for (i = 0; i < `PGPIO_PORT_W; i = i + 1) begin : g_bit
      assign level_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : level_r[i];
      // Push-pull drives the data bit both ways
      // Open-drain pulls low on 0 and releases on 1
      assign out_nxt[i] = PRESENT[i] & port.mode[i] & port.data[i];
      assign oe_nxt[i]  = PRESENT[i] & (port.mode[i] | ~port.data[i]);
    end
  endgenerate

  // Pull-ups follow the global disable only
  assign pu_nxt = PRESENT & {`PGPIO_PORT_W{~port.pu_dis}};

  // Absent pins read as zero
  assign port.level = level_r & PRESENT;

  // Registered pin controls; reset leaves every pin released, pull-ups on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r   <= `PGPIO_LEVEL_RST;
      pin_out   <= `PGPIO_MODE_RST;
      pin_oe    <= `PGPIO_MODE_RST;
      pullup_en <= PRESENT;
    end else begin
      level_r   <= level_nxt;
      pin_out   <= out_nxt;
      pin_oe    <= oe_nxt;
      pullup_en <= pu_nxt;
    end
  end

endmodule

/* File: pgpio_top_sva.sv */
// Checker for the paged GPIO port registers and pin drive
`timescale 1ns/100ps
module pgpio_top_sva (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  // Register access
  input wire logic [7:0]  SFR_PAGE,
  input wire logic [7:0]  SFR_ADDR,
  input wire logic        SFR_WR,
  input wire logic [7:0]  SFR_WDATA,
  input wire logic        SFR_RD,
  input wire logic [7:0]  SFR_RDATA,
  input wire logic        SFR_RVALID,
  input wire logic        SFR_HIT,
  // Pins
  input wire logic        WEAK_PULLUP_DIS,
  input wire logic [31:0] PIN_OUT,
  input wire logic [31:0] PIN_OE,
  input wire logic [31:0] PULLUP_EN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Request qualifiers
  wire off_pg = SFR_PAGE != 8'h0F;
  wire rd_ok  = SFR_RD && !SFR_WR;
  // Port five data write, then pins follow two cycles later
  sequence s_wr5;
    SFR_WR && !off_pg && SFR_ADDR == 8'hD8;
  endsequence
  sequence s_drv5;
    SFR_HIT ##1 PIN_OUT[15:8] == ($past(SFR_WDATA, 2) & PIN_OE[15:8]);
  endsequence
  property p_rd_valid; rd_ok |=> SFR_RVALID; endproperty
  property p_off_hit; (SFR_WR || SFR_RD) && off_pg |=> !SFR_HIT; endproperty
  property p_off_rd; rd_ok && off_pg |=> SFR_RDATA == 8'h00; endproperty
  property p_p4_idle; PIN_OE[4:0] == 5'h00 && PULLUP_EN[4:0] == 5'h00; endproperty
  property p_pullup; PULLUP_EN[31:5] == {27{!$past(WEAK_PULLUP_DIS)}}; endproperty
  property p_wr_drive; s_wr5 |=> s_drv5; endproperty
  property p_mode_hit; SFR_WR && !off_pg && SFR_ADDR == 8'h9D |=> SFR_HIT; endproperty
  property p_rst_od; $rose(RST_N) |-> PIN_OE == 32'h0; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  a_off_hit: assert property (p_off_hit) else $error("off page hit");
  a_off_rd: assert property (p_off_rd) else $error("off page read data");
  a_p4_idle: assert property (p_p4_idle) else $error("absent pin active");
  a_pullup: assert property (p_pullup) else $error("pull-up state");
  a_wr_drive: assert property (p_wr_drive) else $error("port drive");
  a_mode_hit: assert property (p_mode_hit) else $error("mode write miss");
  a_rst_od: assert property (p_rst_od) else $error("pin driven at reset");
endmodule
bind pgpio_top pgpio_top_sva u_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .SFR_PAGE(SFR_PAGE),
  .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD),
  .SFR_RDATA(SFR_RDATA), .SFR_RVALID(SFR_RVALID), .SFR_HIT(SFR_HIT),
  .WEAK_PULLUP_DIS(WEAK_PULLUP_DIS), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .PULLUP_EN(PULLUP_EN));

/* File: pgpio_pin_model.sv */
// External circuitry on the port pins
`timescale 1ns/100ps
module pgpio_pin_model (
  // Clock
  input  wire logic        clk,
  // Device side
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pullup_en,
  // Outside drivers and resolved level
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output logic [31:0]      pin_lvl
);
  logic [31:0] flt_r = 32'h0;
  // Unpulled lines wander so a stale level never passes
  always_ff @(posedge clk) begin
    flt_r <= ~flt_r;
  end
  // Released pin takes outside driver, else pull-up, else noise
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & (pullup_en | flt_r));
endmodule

/* File: paged_gpio_ports_four_to_seven_tb_top.sv */
// Self-checking bench for the paged GPIO ports 4..7 block
`timescale 1ns/100ps
module paged_gpio_ports_four_to_seven_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rmw = 1'b0, pu_dis = 1'b0;
  logic [7:0]  page = 8'h00, addr = 8'h00, wdata = 8'h00, rdata;
  logic        rvalid, hit;
  logic [31:0] ext_en = 32'h0, ext_val = 32'h0, lvl, pout, poe, pu;
  int          miscompares = 0, samples_checked = 0;
  // Clock, 4 ns period
  always #2 clk = ~clk;
  pgpio_top DUT (.REF_CLK(clk), .RST_N(rst_n), .SFR_PAGE(page), .SFR_ADDR(addr), .SFR_WR(wr),
    .SFR_WDATA(wdata), .SFR_RD(rd), .SFR_RMW(rmw), .SFR_RDATA(rdata), .SFR_RVALID(rvalid),
    .SFR_HIT(hit), .WEAK_PULLUP_DIS(pu_dis), .PIN_IN(lvl), .PIN_OUT(pout), .PIN_OE(poe),
    .PULLUP_EN(pu));
  pgpio_pin_model u_pins (.clk(clk), .pin_out(pout), .pin_oe(poe), .pullup_en(pu),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(lvl));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One strobed access; read answer is registered at the taken edge
  task automatic acc(input logic w, r, m, input logic [7:0] pg, ad, wd);
    tick(1);
    {wr, rd, rmw, page, addr, wdata} = {w, r, m, pg, ad, wd};
    tick(1);
    {wr, rd, rmw} = 3'b000;
  endtask
  task automatic rchk(input string what, input logic m, input logic [7:0] pg, ad, exp);
    acc(1'b0, 1'b1, m, pg, ad, 8'h00);
    chk(what, rdata, exp);
    chk("rvalid", rvalid, 1'b1);
    chk("hit", hit, pg == 8'h0F);
  endtask
  task automatic t_reset;
    chk("oe", poe, 32'h0);
    for (int p = 0; p < 4; p++) begin
      rchk("mode", 1'b0, 8'h0F, 8'h9C + 8'(p), 8'h00);
      rchk("data", 1'b1, 8'h0F, 8'hC8 + 8'(16 * p), p == 0 ? 8'hE0 : 8'hFF);
    end
  endtask
  task automatic t_page;
    acc(1'b1, 1'b0, 1'b0, 8'h0E, 8'hD8, 8'h00);
    rchk("off page", 1'b0, 8'h0E, 8'hD8, 8'h00);
    rchk("data5", 1'b1, 8'h0F, 8'hD8, 8'hFF);
  endtask
  // Reset in mid-run while port five drives low
  task automatic t_rerun;
    acc(1'b1, 1'b0, 1'b0, 8'h0F, 8'h9D, 8'hFF);
    acc(1'b1, 1'b0, 1'b0, 8'h0F, 8'hD8, 8'h00);
    tick(1);
    chk("low oe", poe[15:8], 8'hFF);
    chk("low out", pout[15:8], 8'h00);
    rst_n = 1'b0;
    tick(2);
    chk("rerun oe", poe, 32'h0);
    rst_n = 1'b1;
    rchk("rerun mode5", 1'b0, 8'h0F, 8'h9D, 8'h00);
    rchk("rerun data5", 1'b1, 8'h0F, 8'hD8, 8'hFF);
  endtask
  task automatic t_drive;
    acc(1'b1, 1'b0, 1'b0, 8'h0F, 8'h9D, 8'hFF);
    acc(1'b1, 1'b0, 1'b0, 8'h0F, 8'hD8, 8'hA5);
    tick(1);
    chk("pp oe", poe[15:8], 8'hFF);
    chk("pp out", pout[15:8], 8'hA5);
    acc(1'b1, 1'b0, 1'b0, 8'h0F, 8'h9D, 8'h00);
    tick(1);
    chk("od oe", poe[15:8], 8'h5A);
    chk("od out", pout[15:8], 8'h00);
  endtask
  // Port six as input, port four with absent low pins
  task automatic t_input;
    acc(1'b1, 1'b0, 1'b0, 8'h0F, 8'hE8, 8'hFF);
    ext_en = 32'h00FF00FF;
    ext_val = 32'h003C005F;
    tick(4);
    rchk("port6", 1'b0, 8'h0F, 8'hE8, 8'h3C);
    rchk("port6 rmw", 1'b1, 8'h0F, 8'hE8, 8'hFF);
    rchk("port4", 1'b0, 8'h0F, 8'hC8, 8'h40);
  endtask
  task automatic t_pullup;
    ext_en = 32'h0;
    tick(4);
    chk("pu on", pu, 32'hFFFFFFE0);
    rchk("port7", 1'b0, 8'h0F, 8'hF8, 8'hFF);
    pu_dis = 1'b1;
    tick(2);
    chk("pu off", pu, 32'h0);
  endtask
  initial begin
    tick(8);
    rst_n = 1'b1;
    t_reset;
    t_page;
    t_drive;
    t_rerun;
    t_input;
    t_pullup;
    stop_test;
  end
  // Guard against a hung run
  initial begin
    tick(5000);
    miscompares++;
    stop_test;
  end
endmodule
